// ===== flash_ctl.sv
// Host-side controller driving a parallel flash's security register and status
// Behaviour
// RQ1 - Security register is two 64-bit halves
// RQ2 - Block A factory value, never written
// RQ3 - Program block B with four-cycle sequence
// RQ4 - Lock block B, lock bit zero
// RQ5 - Read 80H in identification mode for lock
// RQ6 - Read register after identification_mode_entry
// RQ7 - Issue identification_mode_exit after such reads
// RQ8 - Completion pin is open-drain, low busy
// RQ9 - Wired-OR completion line shared
// RQ10 - Query entry writes 98h at 55h
// RQ11 - Query entry from read or id mode
// RQ12 - Leave query only by exit command
// RQ13 - No programming within 10 ms of power-up
// RQ14 - Program inhibited unless gate high, selected
// RQ15 - Erase suspend sector status bits
// RQ16 - Program during erase suspend status
// RQ17 - Program suspend sector status bits
// RQ18 - Outside suspended sector reads true data
// RQ19 - Timeout-fail bit marks failure
// RQ20 - Recheck polling bit after fail
// RQ21 - Recheck toggle bit after fail
// RQ22 - Poll inside erased sector address
// RQ23 - Config 01 polling low while busy
// RQ24 - Toggle bit alternates while busy
// RQ25 - Exit command after timeout-fail
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module flash_ctl #(
  parameter int PWR_DLY = flash_ctl_pkg::PWR_DLY_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [18:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic flash_rdy_in
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_STROBE = 6'b000100,
    ST_HOLD = 6'b001000,
    ST_READ = 6'b010000,
    ST_NEXT = 6'b100000
  } st_t;

  st_t st_ff, nxt_st;
  flash_ctl_pkg::flash_bus_t bus_ff, nxt_bus;
  flash_ctl_pkg::ahb_req_t req_ff, nxt_req;
  logic [3:0] op_ff, nxt_op;
  logic [2:0] step_ff, nxt_step;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [18:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] prev_ff, nxt_prev;
  logic [15:0] sec_ff [8];
  logic [15:0] nxt_sec [8];
  logic [2:0] widx_ff, nxt_widx;
  logic [23:0] pwr_ff, nxt_pwr;
  logic id_mode_ff, nxt_id_mode;
  logic query_ff, nxt_query;
  logic locked_ff, nxt_locked;
  logic fail_ff, nxt_fail;
  logic toggling_ff, nxt_toggling;
  logic err_ff, nxt_err;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hrdy_ff, nxt_hrdy;
  logic rdy_ff, nxt_rdy;

  logic busy;
  logic [2:0] nseq;
  logic [11:0] seq_a;
  logic [15:0] seq_d;
  logic is_write, is_last;
  logic [2:0] nxt_widx_seq;

  assign busy = (st_ff != ST_IDLE);

  // Sequence table: cycle address/data per command step
  always_comb begin
    seq_a = flash_ctl_pkg::FA_555;
    seq_d = flash_ctl_pkg::FD_AA;
    nseq = 3'd1;
    is_write = 1'b1;
    unique case (step_ff)
      3'd0: begin
        seq_a = flash_ctl_pkg::FA_555;
        seq_d = flash_ctl_pkg::FD_AA;
      end
      3'd1: begin
        seq_a = flash_ctl_pkg::FA_AAA;
        seq_d = flash_ctl_pkg::FD_55;
      end
      default: begin
        seq_a = flash_ctl_pkg::FA_555;
        seq_d = flash_ctl_pkg::FD_90;
      end
    endcase
    unique case (op_ff)
      flash_ctl_pkg::OP_READ, flash_ctl_pkg::OP_POLL,
      flash_ctl_pkg::OP_SEC_READ: begin
        nseq = 3'd1;
        is_write = 1'b0;
      end
      flash_ctl_pkg::OP_QUERY: begin
        nseq = 3'd1;
        seq_a = flash_ctl_pkg::FA_QUERY; // [RQ10] [RQ11]
        seq_d = flash_ctl_pkg::FD_98;
      end
      flash_ctl_pkg::OP_ID_ENTRY: begin
        nseq = 3'd3; // [RQ6]
      end
      flash_ctl_pkg::OP_ID_EXIT: begin
        nseq = 3'd3; // [RQ7] [RQ12] [RQ25]
        if (step_ff == 3'd2) begin
          seq_d = flash_ctl_pkg::FD_F0;
        end
      end
      flash_ctl_pkg::OP_SEC_PROG, flash_ctl_pkg::OP_SEC_LOCK: begin
        nseq = 3'd4; // [RQ3] [RQ4]
        if (step_ff == 3'd2) begin
          seq_d = flash_ctl_pkg::FD_C0;
        end
        if (step_ff == 3'd3) begin
          seq_a = 12'(addr_ff);
          seq_d = wdata_ff;
          if (op_ff == flash_ctl_pkg::OP_SEC_LOCK) begin
            seq_a = flash_ctl_pkg::FA_LOCK;
            seq_d = flash_ctl_pkg::FD_LOCK; // [RQ4]
          end
        end
      end
      flash_ctl_pkg::OP_LOCK_STAT: begin
        nseq = 3'd4; // [RQ5]
        if (step_ff == 3'd3) begin
          seq_a = flash_ctl_pkg::FA_LOCK;
          is_write = 1'b0;
        end
      end
      default: nseq = 3'd1;
    endcase
    if (op_ff == flash_ctl_pkg::OP_READ || op_ff == flash_ctl_pkg::OP_POLL
        || op_ff == flash_ctl_pkg::OP_SEC_READ) begin
      seq_a = 12'(addr_ff); // [RQ22]
    end
    is_last = (step_ff == nseq - 3'd1);
  end

  // Flash bus sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_bus = bus_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    nxt_rdata = rdata_ff;
    nxt_prev = prev_ff;
    nxt_sec = sec_ff;
    nxt_id_mode = id_mode_ff;
    nxt_query = query_ff;
    nxt_locked = locked_ff;
    nxt_fail = fail_ff;
    nxt_toggling = toggling_ff;
    nxt_rdy = flash_rdy_in; // [RQ8] [RQ9]
    nxt_pwr = (pwr_ff == 24'd0) ? 24'd0 : pwr_ff - 24'd1; // [RQ13]
    unique case (st_ff)
      ST_IDLE: begin
        nxt_bus.ce_n = 1'b1;
        nxt_bus.oe_n = 1'b1;
        nxt_bus.we_n = 1'b1;
        nxt_bus.oe_data = 1'b0;
        nxt_step = 3'd0;
      end
      ST_SETUP: begin
        // Addresses set with all strobes inactive
        nxt_bus.addr = 19'(seq_a);
        if (op_ff == flash_ctl_pkg::OP_SEC_READ) begin
          nxt_bus.addr = flash_ctl_pkg::SEC_BASE + 19'(widx_ff);
        end else if (op_ff == flash_ctl_pkg::OP_READ ||
                     op_ff == flash_ctl_pkg::OP_POLL) begin
          nxt_bus.addr = addr_ff; // [RQ22]
        end
        nxt_bus.dout = seq_d;
        nxt_bus.oe_data = is_write;
        nxt_bus.oe_n = 1'b1; // [RQ14]
        nxt_bus.ce_n = 1'b0;
        nxt_cnt = flash_ctl_pkg::ACC_CYC;
        nxt_st = is_write ? ST_STROBE : ST_READ;
      end
      ST_STROBE: begin
        nxt_bus.we_n = 1'b0; // [RQ14]
        nxt_cnt = cnt_ff - 4'd1;
        if (cnt_ff == 4'd1) begin
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Select stays low one cycle past the strobe edge
        nxt_bus.we_n = 1'b1;
        nxt_st = ST_NEXT;
      end
      ST_READ: begin
        nxt_bus.oe_n = 1'b0;
        nxt_cnt = cnt_ff - 4'd1;
        if (cnt_ff == 4'd1) begin
          nxt_rdata = flash_dq_in;
          nxt_bus.oe_n = 1'b1;
          nxt_bus.ce_n = 1'b1;
          nxt_st = ST_NEXT;
        end
      end
      ST_NEXT: begin
        nxt_bus.ce_n = 1'b1;
        nxt_st = ST_SETUP;
        nxt_step = step_ff + 3'd1;
        if (is_last) begin
          nxt_st = ST_IDLE;
          unique case (op_ff)
            flash_ctl_pkg::OP_ID_ENTRY: nxt_id_mode = 1'b1;
            flash_ctl_pkg::OP_QUERY: nxt_query = 1'b1; // [RQ11]
            flash_ctl_pkg::OP_ID_EXIT: begin
              nxt_id_mode = 1'b0; // [RQ12]
              nxt_query = 1'b0;
              nxt_fail = 1'b0; // [RQ25]
            end
            flash_ctl_pkg::OP_LOCK_STAT: begin
              nxt_id_mode = 1'b1;
              nxt_locked = ~rdata_ff[flash_ctl_pkg::LOCK_BIT]; // [RQ5]
            end
            flash_ctl_pkg::OP_SEC_READ: begin
              nxt_sec[widx_ff] = rdata_ff; // [RQ1] [RQ6]
              if (widx_ff != 3'd7) begin
                nxt_st = ST_SETUP;
                nxt_step = 3'd0;
              end
            end
            flash_ctl_pkg::OP_POLL: begin
              // Toggle-bit check against the previous read; fail bit sampled with it
              nxt_toggling = rdata_ff[flash_ctl_pkg::TOGGLE_BIT] !=
                prev_ff[flash_ctl_pkg::TOGGLE_BIT]; // [RQ24] [RQ21]
              nxt_prev = rdata_ff; // [RQ20] [RQ23]
              nxt_fail = fail_ff | rdata_ff[flash_ctl_pkg::FAIL_BIT]; // [RQ19]
            end
            default: nxt_st = ST_IDLE;
          endcase
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Register slave: decode and command issue
  logic wr_ok;
  always_comb begin
    nxt_req = req_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_err = err_ff;
    nxt_hrdata = hrdata_ff;
    nxt_hrdy = 1'b1;
    nxt_widx = 3'd0;
    wr_ok = 1'b1;
    if (hready) begin
      nxt_req.htrans = hsel ? htrans : 2'b00;
      nxt_req.hwrite = hwrite;
      nxt_req.haddr = haddr;
    end
    if (req_ff.htrans[1] && req_ff.hwrite) begin
      unique case (req_ff.haddr)
        flash_ctl_pkg::REG_ADDR: nxt_addr = hwdata[18:0];
        flash_ctl_pkg::REG_WDATA: nxt_wdata = hwdata[15:0];
        flash_ctl_pkg::REG_CMD: begin
          // Block A words and locked block B are refused
          if (hwdata[3:0] == flash_ctl_pkg::OP_SEC_PROG) begin
            wr_ok = ~locked_ff && (addr_ff >= flash_ctl_pkg::SEC_BASE
              + 19'(flash_ctl_pkg::SEC_B_FIRST)); // [RQ2] [RQ3]
          end
          if (hwdata[3:0] == flash_ctl_pkg::OP_SEC_PROG ||
              hwdata[3:0] == flash_ctl_pkg::OP_SEC_LOCK) begin
            wr_ok = wr_ok && (pwr_ff == 24'd0); // [RQ13]
          end
          if (busy || !wr_ok) begin
            nxt_err = 1'b1;
          end else begin
            nxt_op = hwdata[3:0];
            nxt_err = 1'b0;
          end
        end
        default: nxt_err = err_ff;
      endcase
    end
    if (nxt_req.htrans[1] && !nxt_req.hwrite && hready) begin
      unique case (nxt_req.haddr)
        flash_ctl_pkg::REG_STATUS: nxt_hrdata = {23'd0, err_ff,
          locked_ff, fail_ff, toggling_ff, query_ff, id_mode_ff,
          rdy_ff, (pwr_ff != 24'd0), busy};
        flash_ctl_pkg::REG_RDATA: nxt_hrdata = {16'd0, rdata_ff};
        flash_ctl_pkg::REG_SEC_LO: nxt_hrdata = {sec_ff[1], sec_ff[0]};
        flash_ctl_pkg::REG_SEC_HI: nxt_hrdata = {sec_ff[5], sec_ff[4]};
        flash_ctl_pkg::REG_ADDR: nxt_hrdata = {13'd0, addr_ff};
        flash_ctl_pkg::REG_WDATA: nxt_hrdata = {16'd0, wdata_ff};
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  logic start;
  assign start = (nxt_op != op_ff) || (req_ff.htrans[1] && req_ff.hwrite
    && req_ff.haddr == flash_ctl_pkg::REG_CMD && !busy && wr_ok);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff <= ST_IDLE;
      bus_ff <= '{addr: '0, dout: '0, oe_data: 1'b0, ce_n: 1'b1,
        oe_n: 1'b1, we_n: 1'b1};
      req_ff <= '0;
      op_ff <= flash_ctl_pkg::OP_NONE;
      step_ff <= 3'd0;
      cnt_ff <= 4'd0;
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      prev_ff <= '0;
      for (int i = 0; i < 8; i++) begin
        sec_ff[i] <= '0;
      end
      widx_ff <= 3'd0;
      pwr_ff <= 24'(PWR_DLY); // [RQ13]
      id_mode_ff <= 1'b0;
      query_ff <= 1'b0;
      locked_ff <= 1'b0;
      fail_ff <= 1'b0;
      toggling_ff <= 1'b0;
      err_ff <= 1'b0;
      hrdata_ff <= flash_ctl_pkg::STATUS_RST;
      hrdy_ff <= 1'b1;
      rdy_ff <= 1'b1;
    end else begin
      st_ff <= (st_ff == ST_IDLE && start) ? ST_SETUP : nxt_st;
      bus_ff <= nxt_bus;
      req_ff <= nxt_req;
      op_ff <= nxt_op;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      prev_ff <= nxt_prev;
      sec_ff <= nxt_sec;
      widx_ff <= (st_ff == ST_IDLE) ? nxt_widx : nxt_widx_seq;
      pwr_ff <= nxt_pwr;
      id_mode_ff <= nxt_id_mode;
      query_ff <= nxt_query;
      locked_ff <= nxt_locked;
      fail_ff <= nxt_fail;
      toggling_ff <= nxt_toggling;
      err_ff <= nxt_err;
      hrdata_ff <= nxt_hrdata;
      hrdy_ff <= nxt_hrdy;
      rdy_ff <= nxt_rdy;
    end
  end

  assign nxt_widx_seq = (st_ff == ST_NEXT && is_last &&
    op_ff == flash_ctl_pkg::OP_SEC_READ) ? widx_ff + 3'd1 : widx_ff;

  assign hrdata = hrdata_ff;
  assign hreadyout = hrdy_ff;
  assign hresp = 1'b0;
  assign flash_addr = bus_ff.addr;
  assign flash_dq_out = bus_ff.dout;
  assign flash_dq_oe = bus_ff.oe_data;
  assign flash_ce_n = bus_ff.ce_n;
  assign flash_oe_n = bus_ff.oe_n;
  assign flash_we_n = bus_ff.we_n;
endmodule : flash_ctl

// ===== flash_ctl_asserts.sv
// Checker for the flash controller's bus and flash pins
`timescale 1ns/1ps
module flash_ctl_asserts #(
  parameter int PWR_DLY = 20
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  logic [31:0] up_ff;
  logic [31:0] nxt_up;
  // Cycles since reset release, saturating
  always_comb begin
    nxt_up = (up_ff == 32'hFFFF_FFFF) ? up_ff : up_ff + 32'h0000_0001;
    if (srst) begin
      nxt_up = 32'h0000_0000;
    end
  end
  always_ff @(posedge core_clk) begin
    up_ff <= nxt_up;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or flagged an error");
  AST_WE_QUALIFIED: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without select or with gate low");
  AST_NO_CONTENTION: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("data driven while flash output gate is low");
  AST_WE_DATA: assert property ($fell(flash_we_n) |-> flash_dq_oe)
    else $error("write strobe without driven data");
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n[*2] ##1 flash_we_n)
    else $error("write strobe not two cycles long");
  AST_WE_HOLD: assert property (!flash_we_n && !$past(flash_we_n) |->
    $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved under write strobe");
  AST_RST_IDLE: assert property ($past(srst) |-> flash_we_n && flash_ce_n && !flash_dq_oe)
    else $error("flash pins active after reset");
  AST_PWR_HOLD: assert property (up_ff < PWR_DLY |-> flash_we_n || flash_dq_out[7:0] != 8'hC0)
    else $error("register program started inside power-up hold-off");
  AST_QUERY_ADDR: assert property (!flash_we_n && flash_dq_out == 16'h0098 |-> flash_addr[7:0] == 8'h55)
    else $error("query entry at wrong address");
endmodule : flash_ctl_asserts

bind flash_ctl flash_ctl_asserts #(.PWR_DLY(PWR_DLY)) flash_ctl_asserts_i (
  .core_clk(core_clk), .srst(srst), .hreadyout(hreadyout), .hresp(hresp),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
);

// ===== flash_ctl_pkg.sv
// Package: register map, commands and flash bus types for the flash controller
package flash_ctl_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_SEC_LO = 8'h14;
  localparam logic [7:0] REG_SEC_HI = 8'h18;
  // Command codes written to REG_CMD
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_ID_ENTRY = 4'h2;
  localparam logic [3:0] OP_ID_EXIT = 4'h3;
  localparam logic [3:0] OP_QUERY = 4'h4;
  localparam logic [3:0] OP_SEC_PROG = 4'h5;
  localparam logic [3:0] OP_SEC_LOCK = 4'h6;
  localparam logic [3:0] OP_LOCK_STAT = 4'h7;
  localparam logic [3:0] OP_SEC_READ = 4'h8;
  localparam logic [3:0] OP_POLL = 4'h9;
  // Flash command addresses and data
  localparam logic [11:0] FA_555 = 12'h555;
  localparam logic [11:0] FA_AAA = 12'hAAA;
  localparam logic [11:0] FA_QUERY = 12'h055;
  localparam logic [11:0] FA_LOCK = 12'h080;
  localparam logic [15:0] FD_AA = 16'h00AA;
  localparam logic [15:0] FD_55 = 16'h0055;
  localparam logic [15:0] FD_90 = 16'h0090;
  localparam logic [15:0] FD_F0 = 16'h00F0;
  localparam logic [15:0] FD_C0 = 16'h00C0;
  localparam logic [15:0] FD_98 = 16'h0098;
  localparam logic [15:0] FD_LOCK = 16'hFFFD;
  // Security register: words 1..8 at 0x81..0x88, block B is words 5..8
  localparam logic [18:0] SEC_BASE = 19'h0_0081;
  localparam logic [2:0] SEC_B_FIRST = 3'h4;
  localparam int LOCK_BIT = 1;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;
  // Bus timing in core_clk cycles (100 ns period)
  localparam int CLK_NS = 100;
  localparam int ACC_NS = 70;
  localparam logic [3:0] ACC_CYC = 4'((ACC_NS + CLK_NS - 1) / CLK_NS + 1);
  // Power-on programming hold-off
  localparam int PWR_DLY_MS = 10;
  localparam int PWR_DLY_CYC = PWR_DLY_MS * 1000000 / CLK_NS;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;

  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] dout;
    logic oe_data;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } flash_bus_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic hwrite;
    logic [7:0] haddr;
  } ahb_req_t;
endpackage : flash_ctl_pkg

// ===== flash_dev_model.sv
// Behavioural flash device: security register, modes, completion pin
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int BUSY_NS = 2000
) (
  input wire logic [18:0] addr,
  input wire logic [15:0] din,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [15:0] dout,
  output logic dout_en,
  output logic busy_low
);
  logic [15:0] sec [8];
  logic [1:0] seq;
  logic id_mode, query, locked, tog;
  initial begin
    for (int i = 0; i < 8; i++) begin
      sec[i] = (i < 4) ? 16'hA500 + 16'(i) : 16'hFFFF; // Arbitrary factory value
    end
    {seq, id_mode, query, locked, tog, busy_low} = '0;
  end
  assign dout_en = !ce_n && !oe_n;
  always @(posedge oe_n) begin
    tog = !tog;
  end
  always_comb begin
    if (busy_low) begin
      dout = {9'h000, tog, 6'h04};
    end else if (id_mode && addr == 19'h80) begin
      dout = {14'h3FFF, !locked, 1'b1};
    end else if (id_mode && addr > 19'h80 && addr < 19'h89) begin
      dout = sec[addr[2:0] - 3'd1];
    end else begin
      dout = ~addr[15:0];
    end
  end
  always @(posedge we_n) begin
    if (!ce_n && oe_n && !busy_low) begin
      if (seq == 2'd3) begin
        seq = 2'd0;
        if (addr == 19'h80 && !din[1]) begin
          locked = 1'b1;
        end else if (addr > 19'h84 && addr < 19'h89 && !locked) begin
          sec[addr[2:0] - 3'd1] = din;
          busy_low = 1'b1;
          #BUSY_NS;
          busy_low = 1'b0;
        end
      end else if (din[7:0] == 8'hF0) begin
        {id_mode, query, seq} = '0;
      end else if (addr[7:0] == 8'h55 && din[7:0] == 8'h98) begin
        query = 1'b1;
      end else if (addr[11:0] == 12'h555 && din[7:0] == 8'hAA) begin
        seq = 2'd1;
      end else if (seq == 2'd1 && addr[11:0] == 12'hAAA && din[7:0] == 8'h55) begin
        seq = 2'd2;
      end else if (seq == 2'd2 && din[7:0] == 8'hC0) begin
        seq = 2'd3;
      end else begin
        id_mode = id_mode || (seq == 2'd2 && din[7:0] == 8'h90);
        seq = 2'd0;
      end
    end
  end
endmodule : flash_dev_model

// ===== test_flash_ctl.sv
// Self-checking bench for the flash controller with a flash device model
`timescale 1ns/1ps
module test_flash_ctl;
  localparam int PWR = 20;
  logic core_clk, srst, hsel, hwrite, hready, rd_dp;
  logic hreadyout, hresp, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic dev_en, dev_busy, flash_rdy_in;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv;
  logic [18:0] flash_addr, a;
  logic [15:0] flash_dq_out, flash_dq_in, dev_dq, rnd;
  logic [63:0] me;
  logic [63:0] expq [$];
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 64155;
  flash_ctl #(.PWR_DLY(PWR)) flash_ctl_i (.core_clk(core_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_rdy_in(flash_rdy_in));
  flash_dev_model #(.BUSY_NS(5000)) flash_dev_model_i (.addr(flash_addr),
    .din(flash_dq_in),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .dout(dev_dq),
    .dout_en(dev_en), .busy_low(dev_busy));
  assign hready = hreadyout;
  // Released bus shows a pattern that moves every cycle
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_en ? dev_dq : 16'(cyc);
  assign flash_rdy_in = !dev_busy;
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 20000) begin
      bad_count++;
      wrap_up;
    end else if (rd_dp === 1'b1) begin
      me = expq.pop_front();
      check(hrdata & me[63:32], me[31:0]);
    end
  end
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, input logic chk);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= chk;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
    rdv = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input logic [31:0] m);
    expq.push_back({m, e});
    xfer(1'b0, ad, '0, 1'b1);
  endtask : rd
  task automatic cmd(input logic [3:0] op);
    xfer(1'b1, flash_ctl_pkg::REG_CMD, {28'h000_0000, op}, 1'b0);
    do begin
      xfer(1'b0, flash_ctl_pkg::REG_STATUS, '0, 1'b0);
    end while (rdv[0] !== 1'b0);
  endtask : cmd
  // Waits for the flash completion line to be released
  task automatic wait_rdy;
    do begin
      xfer(1'b0, flash_ctl_pkg::REG_STATUS, '0, 1'b0);
    end while (rdv[2] !== 1'b1);
  endtask : wait_rdy
  task automatic prog(input logic [31:0] ad, input logic [31:0] d);
    xfer(1'b1, flash_ctl_pkg::REG_ADDR, ad, 1'b0);
    xfer(1'b1, flash_ctl_pkg::REG_WDATA, d, 1'b0);
    cmd(flash_ctl_pkg::OP_SEC_PROG);
  endtask : prog
  task automatic sec_chk(input logic [7:0] ad, input logic [31:0] e);
    cmd(flash_ctl_pkg::OP_ID_ENTRY);
    cmd(flash_ctl_pkg::OP_SEC_READ);
    rd(ad, e, '1);
    cmd(flash_ctl_pkg::OP_ID_EXIT);
  endtask : sec_chk
  task automatic st_chk(input logic [31:0] e, input logic [31:0] m);
    rd(flash_ctl_pkg::REG_STATUS, e, m);
  endtask : st_chk
  initial begin
    {hsel, htrans, haddr, hwrite, hsize, hwdata, rd_dp} = '0;
    srst = 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    prog(32'h0000_0085, 32'h0000_1234);
    st_chk(32'h0000_0100, 32'h0000_0100);
    $display("test power-up hold-off done");
    repeat (PWR) @(posedge core_clk);
    sec_chk(flash_ctl_pkg::REG_SEC_LO, 32'hA501_A500);
    cmd(flash_ctl_pkg::OP_ID_ENTRY);
    cmd(flash_ctl_pkg::OP_LOCK_STAT);
    st_chk(32'h0000_0000, 32'h0000_0080);
    cmd(flash_ctl_pkg::OP_ID_EXIT);
    rnd = (16'($random(seed)) & 16'h3FFF) | 16'h4000;
    prog(32'h0000_0085, {16'h0000, rnd});
    cmd(flash_ctl_pkg::OP_POLL);
    cmd(flash_ctl_pkg::OP_POLL);
    st_chk(32'h0000_0020, 32'h0000_0064);
    rd(flash_ctl_pkg::REG_RDATA, 32'h0000_0004, 32'h0000_00A4);
    wait_rdy;
    sec_chk(flash_ctl_pkg::REG_SEC_HI, {16'hFFFF, rnd});
    prog(32'h0000_0081, 32'h0000_0000);
    st_chk(32'h0000_0100, 32'h0000_0100);
    sec_chk(flash_ctl_pkg::REG_SEC_LO, 32'hA501_A500);
    $display("test register program done");
    cmd(flash_ctl_pkg::OP_SEC_LOCK);
    cmd(flash_ctl_pkg::OP_ID_ENTRY);
    cmd(flash_ctl_pkg::OP_LOCK_STAT);
    st_chk(32'h0000_0080, 32'h0000_0080);
    cmd(flash_ctl_pkg::OP_ID_EXIT);
    prog(32'h0000_0085, {16'h0000, ~rnd});
    sec_chk(flash_ctl_pkg::REG_SEC_HI, {16'hFFFF, rnd});
    $display("test lock done");
    cmd(flash_ctl_pkg::OP_QUERY);
    st_chk(32'h0000_0010, 32'h0000_0010);
    cmd(flash_ctl_pkg::OP_ID_EXIT);
    st_chk(32'h0000_0000, 32'h0000_0018);
    cmd(flash_ctl_pkg::OP_ID_ENTRY);
    cmd(flash_ctl_pkg::OP_QUERY);
    st_chk(32'h0000_0010, 32'h0000_0010);
    cmd(flash_ctl_pkg::OP_ID_EXIT);
    $display("test query done");
    a = (19'($random(seed)) & 19'h7_FF7F) | 19'h0_0020;
    xfer(1'b1, flash_ctl_pkg::REG_ADDR, {13'h0000, a}, 1'b0);
    cmd(flash_ctl_pkg::OP_READ);
    rd(flash_ctl_pkg::REG_RDATA, {16'h0000, ~a[15:0]}, 32'h0000_FFFF);
    cmd(flash_ctl_pkg::OP_POLL);
    st_chk(32'h0000_0004, 32'h0000_0045);
    $display("test read and poll done");
    repeat (2) @(posedge core_clk);
    wrap_up;
  end
endmodule : test_flash_ctl
